// File: shared/port_ctl_params.svh
// constants for the per-port interrupt mask and operation control bank
`ifndef PORT_CTL_PARAMS_SVH
`define PORT_CTL_PARAMS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define PC_ADDR_W 16
`define PC_DATA_W 8
`define PC_OFS_STATUS 12'h01B
`define PC_OFS_MASK 12'h01F
`define PC_OFS_OPCTL 12'h020
`define PC_ADR_EVT_STAT 16'h0010
`define PC_ADR_EVT_MASK 16'h0011

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PC_BIT_PTP 2
`define PC_BIT_PHY 1
`define PC_BIT_ACL 0
`define PC_BIT_LLOOP 7
`define PC_BIT_RLOOP 6
`define PC_BIT_TTAG 2
`define PC_QS_HI 1
`define PC_QS_LO 0
`define PC_RST_MASK 3'h0
`define PC_RST_OPCTL 8'h00
`define PC_QS_RSVD 2'h3

`endif

// File: shared/port_ctl_pkg.sv
// types shared by the port control register bank
package port_ctl_pkg;

   typedef enum logic [1:0] {
      QS_ONE = 2'h0,
      QS_TWO = 2'h1,
      QS_FOUR = 2'h2,
      QS_RSVD = 2'h3
   } qsplit_e;

   typedef struct packed {
      logic local_loop;
      logic remote_loop;
      logic tail_tag;
      qsplit_e qsplit;
   } opctl_s;

   typedef struct packed {
      logic ptp;
      logic phy;
      logic access_control_list;
   } irq_src_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic fabric_return;
      logic line_loop;
      logic pin_loop;
      logic host_port;
   } path_ctl_s;

   typedef struct packed {
      logic [2:0] mask;
      opctl_s opc;
      logic port_irq;
      path_ctl_s path;
   } port_state_s;

endpackage : port_ctl_pkg

// File: design/irq_source_latch.sv
// one port interrupt status bit: sticky event latch or level follower
`timescale 1ns/1ns
module irq_source_latch #(
   parameter bit STICKY = 1'b1,
   parameter bit PRESENT = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // source and clear
   input wire logic src,
   input wire logic clr,
   // status
   output logic stat_r
);
   typedef struct packed {
      logic stat;
   } latch_s;

   latch_s st_r;
   latch_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!PRESENT) begin
         st_nxt.stat = 1'b0;
      end else if (STICKY) begin
         // a new event beats a clear in the same cycle
         st_nxt.stat = src | (st_r.stat & ~clr);
      end else begin
         st_nxt.stat = src;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign stat_r = st_r.stat;
endmodule : irq_source_latch

// File: design/egress_queue_map.sv
// priority to egress queue mapping for one queue split setting
`timescale 1ns/1ns
module egress_queue_map
   import port_ctl_pkg::*;
(
   // lookup
   input port_ctl_pkg::qsplit_e qsplit,
   input wire logic [2:0] prio,
   output logic [1:0] queue
);
   function automatic logic [1:0] map_q(input qsplit_e qs, input logic [2:0] p);
      logic [1:0] q;
      q = 2'h0;
      unique case (qs)
         QS_TWO: q = {1'b0, p[2]};
         QS_FOUR: q = p[2:1];
         // single queue and the reserved code share queue 0
         QS_ONE, QS_RSVD: q = 2'h0;
      endcase
      return q;
   endfunction : map_q

   always_comb begin
      queue = map_q(qsplit, prio);
   end
endmodule : egress_queue_map

// File: design/port_irq_op_regs.sv
// per-port interrupt mask and operation control register bank
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "port_ctl_params.svh"

// Behaviour
// - per-port mask gates status sources; 0 enables, 1 disables; resets to 0
// - mask bit 2 gates the aggregated time interrupt, real only on PHY ports
// - mask bit 1 gates the aggregated PHY interrupt, absent on the MAC port
// - mask bit 0 gates the access list interrupt on every port
// - mask register is 8 bits at offset 0x01F per port; bits 7:3 read zero
// - local loopback bit 7 returns egress fabric frames back into the fabric
// - remote loopback bit 6 resends received port data, bypassing the fabric
// - PHY ports loop line receive to transmit; MAC port loops TXD to RXD
// - bit 2 enables tail tagging, marking the port as host port
// - bits 1:0 pick one, two or four egress queues; 11 reserved; reset 00
// - two or four queues sort by priority; one queue ignores priority
// - control register 8 bits at 0x020; bits 5:3 read zero; resets to zero
// - toggling the access list mask bit clears its latched status
module port_irq_op_regs
   import port_ctl_pkg::*;
#(
   parameter int NUM_PORTS = 3,
   parameter int MAC_PORT = 3,
   parameter int PW = $clog2(NUM_PORTS)
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // register port
   input port_ctl_pkg::reg_req_s req,
   output logic [7:0] rdata,
   // interrupt sources, same clock
   input port_ctl_pkg::irq_src_s [NUM_PORTS-1:0] src,
   // queue lookup
   input wire logic [PW-1:0] map_port,
   input wire logic [2:0] map_prio,
   output logic [1:0] map_queue,
   // per-port controls
   output port_ctl_pkg::path_ctl_s [NUM_PORTS-1:0] path,
   output port_ctl_pkg::qsplit_e [NUM_PORTS-1:0] qsplit,
   // interrupts
   output logic [NUM_PORTS-1:0] port_irq,
   output logic irq
);
   import port_ctl_pkg::*;

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   generate
      if (NUM_PORTS < 2 || NUM_PORTS > 8 || MAC_PORT < 1 || MAC_PORT > NUM_PORTS
          || PW != $clog2(NUM_PORTS)) begin : g_bad
         $error("port_irq_op_regs: unsupported port count or MAC port");
      end
   endgenerate

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      port_state_s [NUM_PORTS-1:0] port;
      logic [NUM_PORTS-1:0] evt_stat;
      logic [NUM_PORTS-1:0] evt_mask;
      logic [7:0] rdata;
      logic irq;
      logic [1:0] map_queue;
   } top_state_s;

   top_state_s st_r;
   top_state_s st_nxt;
   logic [NUM_PORTS-1:0][2:0] stat;
   logic [NUM_PORTS-1:0] acl_clr;
   logic [1:0] map_q;

   function automatic logic port_hit(input logic [15:0] a, input int p, input logic [11:0] ofs);
      return (a[15:12] == 4'(p + 1)) && (a[11:0] == ofs);
   endfunction : port_hit

   function automatic logic [7:0] opc_pack(input opctl_s o);
      // reserved bits 5:3 always read zero
      return {o.local_loop, o.remote_loop, 3'h0, o.tail_tag, o.qsplit};
   endfunction : opc_pack

   // ----------------------------------------------------------------
   // status sources
   // ----------------------------------------------------------------
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_src
         // time source only on PHY ports
         irq_source_latch #(.STICKY(1'b0), .PRESENT(p + 1 != MAC_PORT)) u_ptp (
            .clk(clk),
            .rst_b(rst_b),
            .ce(ce),
            .src(src[p].ptp),
            .clr(1'b0),
            .stat_r(stat[p][`PC_BIT_PTP])
         );
         // PHY source absent on MAC port
         irq_source_latch #(.STICKY(1'b0), .PRESENT(p + 1 != MAC_PORT)) u_phy (
            .clk(clk),
            .rst_b(rst_b),
            .ce(ce),
            .src(src[p].phy),
            .clr(1'b0),
            .stat_r(stat[p][`PC_BIT_PHY])
         );
         // access list source on every port
         irq_source_latch #(.STICKY(1'b1), .PRESENT(1'b1)) u_acl (
            .clk(clk),
            .rst_b(rst_b),
            .ce(ce),
            .src(src[p].access_control_list),
            .clr(acl_clr[p]),
            .stat_r(stat[p][`PC_BIT_ACL])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // acl clear on mask toggle
   // ----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         acl_clr[p] = req.wr && port_hit(req.addr, p, `PC_OFS_MASK)
                      && (req.wdata[`PC_BIT_ACL] != st_r.port[p].mask[`PC_BIT_ACL]);
      end
   end

   // ----------------------------------------------------------------
   // queue lookup
   // ----------------------------------------------------------------
   egress_queue_map u_map (
      .qsplit(st_r.port[map_port].opc.qsplit),
      .prio(map_prio),
      .queue(map_q)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 8'h00;
      st_nxt.map_queue = map_q;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (req.wr && port_hit(req.addr, p, `PC_OFS_MASK)) begin
            st_nxt.port[p].mask = req.wdata[2:0];
         end
         if (req.wr && port_hit(req.addr, p, `PC_OFS_OPCTL)) begin
            st_nxt.port[p].opc.local_loop = req.wdata[`PC_BIT_LLOOP];
            st_nxt.port[p].opc.remote_loop = req.wdata[`PC_BIT_RLOOP];
            st_nxt.port[p].opc.tail_tag = req.wdata[`PC_BIT_TTAG];
            if (req.wdata[`PC_QS_HI:`PC_QS_LO] != `PC_QS_RSVD) begin
               st_nxt.port[p].opc.qsplit = qsplit_e'(req.wdata[`PC_QS_HI:`PC_QS_LO]);
            end
         end
         if (req.rd && port_hit(req.addr, p, `PC_OFS_MASK)) begin
            st_nxt.rdata = {5'h00, st_r.port[p].mask};
         end
         if (req.rd && port_hit(req.addr, p, `PC_OFS_OPCTL)) begin
            st_nxt.rdata = opc_pack(st_r.port[p].opc);
         end
         if (req.rd && port_hit(req.addr, p, `PC_OFS_STATUS)) begin
            st_nxt.rdata = {5'h00, stat[p]};
         end
         // mask bit 0 enables a source
         st_nxt.port[p].port_irq = |(stat[p] & ~st_r.port[p].mask);
         st_nxt.port[p].path.fabric_return = st_nxt.port[p].opc.local_loop;
         // PHY line loop or MAC pin loop
         st_nxt.port[p].path.line_loop = st_nxt.port[p].opc.remote_loop && (p + 1 != MAC_PORT);
         st_nxt.port[p].path.pin_loop = st_nxt.port[p].opc.remote_loop && (p + 1 == MAC_PORT);
         // host port is taken as unique
         st_nxt.port[p].path.host_port = st_nxt.port[p].opc.tail_tag;
         // a new port request beats a read clear
         if (st_nxt.port[p].port_irq && !st_r.port[p].port_irq) begin
            st_nxt.evt_stat[p] = 1'b1;
         end else if (req.rd && req.addr == `PC_ADR_EVT_STAT) begin
            st_nxt.evt_stat[p] = 1'b0;
         end
      end
      if (req.wr && req.addr == `PC_ADR_EVT_MASK) begin
         st_nxt.evt_mask = req.wdata[NUM_PORTS-1:0];
      end
      if (req.rd && req.addr == `PC_ADR_EVT_STAT) begin
         st_nxt.rdata = 8'(st_r.evt_stat);
      end
      if (req.rd && req.addr == `PC_ADR_EVT_MASK) begin
         st_nxt.rdata = 8'(st_r.evt_mask);
      end
      // summary line lags the sticky bits by one cycle
      st_nxt.irq = |(st_r.evt_stat & ~st_r.evt_mask);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         // everything, masks included, resets to zero
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      rdata = st_r.rdata;
      irq = st_r.irq;
      map_queue = st_r.map_queue;
      for (int p = 0; p < NUM_PORTS; p++) begin
         path[p] = st_r.port[p].path;
         qsplit[p] = st_r.port[p].opc.qsplit;
         port_irq[p] = st_r.port[p].port_irq;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
         a_mask_reset: assert property (
            @(posedge clk) !rst_b |=> (st_r.port[p].mask == `PC_RST_MASK) && !port_irq[p])
            else $error("mask not cleared by reset");

         a_mask_write: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && req.wr && port_hit(req.addr, p, `PC_OFS_MASK) |=>
            st_r.port[p].mask == $past(req.wdata[2:0]))
            else $error("mask write lost");

         a_mask_gate: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && (stat[p][`PC_BIT_ACL] && !st_r.port[p].mask[`PC_BIT_ACL]) |=> port_irq[p])
            else $error("unmasked acl source did not raise port request");

         a_mask_block: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && ((stat[p] & ~st_r.port[p].mask) == 3'h0) |=> !port_irq[p])
            else $error("masked sources raised port request");

         a_acl_toggle: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && acl_clr[p] && !src[p].access_control_list |=> !stat[p][`PC_BIT_ACL])
            else $error("acl status survived mask toggle");

         a_acl_set_wins: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && src[p].access_control_list |=> stat[p][`PC_BIT_ACL])
            else $error("acl event lost");

         a_opc_read: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && req.rd && port_hit(req.addr, p, `PC_OFS_OPCTL) |=>
            rdata[5:3] == 3'h0 && rdata[7] == $past(st_r.port[p].opc.local_loop))
            else $error("control read wrong");

         a_qs_rsvd: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && req.wr && port_hit(req.addr, p, `PC_OFS_OPCTL) && req.wdata[1:0] == `PC_QS_RSVD
            |=> $stable(qsplit[p]))
            else $error("reserved queue split taken");

         a_loop_path: assert property (
            @(posedge clk) disable iff (!rst_b)
            path[p].fabric_return == st_r.port[p].opc.local_loop
            && (path[p].line_loop | path[p].pin_loop) == st_r.port[p].opc.remote_loop
            && !(path[p].line_loop && path[p].pin_loop))
            else $error("loopback path mismatch");

         a_host_port: assert property (
            @(posedge clk) disable iff (!rst_b)
            path[p].host_port == st_r.port[p].opc.tail_tag)
            else $error("host port mismatch");

         a_mask_read: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && req.rd && port_hit(req.addr, p, `PC_OFS_MASK) |=>
            rdata == {5'h00, $past(st_r.port[p].mask)})
            else $error("mask read wrong");

         a_stat_read: assert property (
            @(posedge clk) disable iff (!rst_b)
            ce && req.rd && port_hit(req.addr, p, `PC_OFS_STATUS) |=>
            rdata == {5'h00, $past(stat[p])})
            else $error("status read wrong");

         a_evt_rise: assert property (
            @(posedge clk) disable iff (!rst_b)
            $rose(port_irq[p]) |-> st_r.evt_stat[p])
            else $error("port request rise not recorded");

         if (p + 1 == MAC_PORT) begin : g_mac
            a_mac_nophy: assert property (
               @(posedge clk) disable iff (!rst_b)
               stat[p][`PC_BIT_PHY] == 1'b0 && stat[p][`PC_BIT_PTP] == 1'b0)
               else $error("MAC port shows PHY status");
         end else begin : g_phy
            a_phy_follow: assert property (
               @(posedge clk) disable iff (!rst_b)
               rst_b && ce |=> stat[p][`PC_BIT_PHY] == $past(src[p].phy))
               else $error("PHY status does not follow its source");

            a_ptp_follow: assert property (
               @(posedge clk) disable iff (!rst_b)
               rst_b && ce |=> stat[p][`PC_BIT_PTP] == $past(src[p].ptp))
               else $error("time status does not follow its source");
         end
      end
   endgenerate

   a_single_queue: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && st_r.port[map_port].opc.qsplit == QS_ONE |=> map_queue == 2'h0)
      else $error("single queue split gave nonzero queue");

   a_rdata_once: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && !req.rd |=> rdata == 8'h00)
      else $error("read data outside read answer cycle");

   a_irq_line: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce ##1 ce |=> irq == $past(|(st_r.evt_stat & ~st_r.evt_mask), 1))
      else $error("interrupt line mismatch");

   a_evt_read: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && req.rd && req.addr == `PC_ADR_EVT_STAT |=> rdata == 8'($past(st_r.evt_stat)))
      else $error("event status read wrong");

   a_ce_freeze: assert property (
      @(posedge clk) disable iff (!rst_b)
      !ce |=> $stable(st_r))
      else $error("state moved while clock enable low");

endmodule : port_irq_op_regs

// File: sim/port_irq_op_regs_test.sv
// self-checking bench for the port interrupt mask and operation control bank
`timescale 1ns/1ns
`include "port_ctl_params.svh"

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module port_irq_op_regs_test;
   import port_ctl_pkg::*;

   // ----------------------------------------------------------------
   // signals and design
   // ----------------------------------------------------------------
   logic clk;
   logic rst_b;
   logic ce;
   reg_req_s req;
   logic [7:0] rdata;
   irq_src_s [2:0] src;
   logic [1:0] map_port;
   logic [2:0] map_prio;
   logic [1:0] map_queue;
   path_ctl_s [2:0] path;
   qsplit_e [2:0] qsplit;
   logic [2:0] port_irq;
   logic irq;
   int mismatches;
   int tests_run;
   logic [11:0] exp_path;
   logic [1:0] es;
   logic [1:0] eq;

   port_irq_op_regs #(.NUM_PORTS(3), .MAC_PORT(3)) dut_u (
      .clk(clk), .rst_b(rst_b), .ce(ce), .req(req), .rdata(rdata), .src(src),
      .map_port(map_port), .map_prio(map_prio), .map_queue(map_queue),
      .path(path), .qsplit(qsplit), .port_irq(port_irq), .irq(irq)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   function automatic logic [15:0] adr(input int p, input logic [11:0] ofs);
      return {4'(p + 1), ofs};
   endfunction : adr

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : tick

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      `CHK(nm, exp, rdata)
   endtask : rd_chk

   task automatic chk_reset();
      for (int p = 0; p < 3; p++) begin
         rd_chk(adr(p, `PC_OFS_MASK), 8'h00, "mask reset");
         rd_chk(adr(p, `PC_OFS_OPCTL), 8'h00, "opctl reset");
         rd_chk(adr(p, `PC_OFS_STATUS), 8'h00, "status reset");
      end
      tick(1);
      `CHK("rdata idle", 8'h00, rdata)
      `CHK("path reset", 12'h000, path)
      `CHK("split reset", 6'h00, qsplit)
      `CHK("irq reset", 4'h0, {port_irq, irq})
   endtask : chk_reset

   // sticky access list event, gated, then cleared by a mask toggle
   task automatic acl_seq(input int p);
      @(posedge clk);
      src[p].access_control_list <= 1'b1;
      @(posedge clk);
      src[p].access_control_list <= 1'b0;
      @(negedge clk);
      `CHK("port_irq early", 1'b0, port_irq[p])
      tick(1);
      `CHK("port_irq set", 1'b1, port_irq[p])
      `CHK("irq early", 1'b0, irq)
      tick(1);
      `CHK("irq set", 1'b1, irq)
      rd_chk(adr(p, `PC_OFS_STATUS), 8'h01, "acl status");
      rd_chk(`PC_ADR_EVT_STAT, 8'(1 << p), "evt status");
      rd_chk(`PC_ADR_EVT_STAT, 8'h00, "evt cleared");
      `CHK("irq cleared", 1'b0, irq)
      wr_reg(adr(p, `PC_OFS_MASK), 8'h01);
      rd_chk(adr(p, `PC_OFS_STATUS), 8'h00, "acl toggled");
      `CHK("port_irq toggled", 1'b0, port_irq[p])
      @(posedge clk);
      src[p].access_control_list <= 1'b1;
      @(posedge clk);
      src[p].access_control_list <= 1'b0;
      tick(3);
      `CHK("acl masked", 1'b0, port_irq[p])
      rd_chk(adr(p, `PC_OFS_STATUS), 8'h01, "masked status");
      wr_reg(adr(p, `PC_OFS_MASK), 8'h00);
      rd_chk(adr(p, `PC_OFS_STATUS), 8'h00, "acl untoggled");
   endtask : acl_seq

   // level source b (1 phy, 2 time) on a PHY port
   task automatic lvl_seq(input int p, input int b);
      @(posedge clk);
      if (b == 1) src[p].phy <= 1'b1;
      else src[p].ptp <= 1'b1;
      tick(2);
      `CHK("level port_irq", 1'b1, port_irq[p])
      rd_chk(adr(p, `PC_OFS_STATUS), 8'(1 << b), "level status");
      wr_reg(`PC_ADR_EVT_MASK, 8'h07);
      tick(1);
      `CHK("evt masked", 1'b0, irq)
      wr_reg(`PC_ADR_EVT_MASK, 8'h00);
      tick(1);
      `CHK("evt unmasked", 1'b1, irq)
      wr_reg(adr(p, `PC_OFS_MASK), 8'(1 << b));
      tick(1);
      `CHK("level masked", 1'b0, port_irq[p])
      @(posedge clk);
      src[p] <= '0;
      wr_reg(adr(p, `PC_OFS_MASK), 8'h00);
      rd_chk(`PC_ADR_EVT_STAT, 8'(1 << p), "evt level");
   endtask : lvl_seq

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      wrap_up();
   end

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      req = '0;
      src = '0;
      map_port = 2'h0;
      map_prio = 3'h0;
      mismatches = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      chk_reset();
      acl_seq(0);
      acl_seq(2);
      for (int b = 1; b < 3; b++) begin
         lvl_seq(0, b);
         lvl_seq(1, b);
      end
      // MAC port carries no time or PHY source
      @(posedge clk);
      src[2].ptp <= 1'b1;
      src[2].phy <= 1'b1;
      tick(3);
      `CHK("mac level irq", 1'b0, port_irq[2])
      rd_chk(adr(2, `PC_OFS_STATUS), 8'h00, "mac status");
      @(posedge clk);
      src[2] <= '0;
      rd_chk(adr(0, `PC_OFS_STATUS), 8'h00, "status idle");
      wr_reg(adr(0, `PC_OFS_MASK), 8'hFF);
      rd_chk(adr(0, `PC_OFS_MASK), 8'h07, "mask reserved");
      wr_reg(adr(0, `PC_OFS_MASK), 8'hF8);
      rd_chk(adr(0, `PC_OFS_MASK), 8'h00, "mask high");
      wr_reg(adr(0, `PC_OFS_OPCTL), 8'h38);
      rd_chk(adr(0, `PC_OFS_OPCTL), 8'h00, "opctl reserved");
      // tail tag is only ever set on one port at a time
      for (int p = 0; p < 3; p++) begin
         exp_path = 12'h000;
         exp_path[p * 4 +: 4] = {1'b1, p != 2, p == 2, 1'b1};
         wr_reg(adr(p, `PC_OFS_OPCTL), 8'hC6);
         @(negedge clk);
         `CHK("loop paths", exp_path, path)
         rd_chk(adr(p, `PC_OFS_OPCTL), 8'hC6, "opctl back");
         wr_reg(adr(p, `PC_OFS_OPCTL), 8'h00);
         @(negedge clk);
         `CHK("paths off", 12'h000, path)
      end
      for (int p = 0; p < 3; p++) begin
         es = 2'h0;
         for (int c = 0; c < 4; c++) begin
            wr_reg(adr(p, `PC_OFS_OPCTL), 8'(c));
            if (c != 3) es = 2'(c);
            rd_chk(adr(p, `PC_OFS_OPCTL), {6'h00, es}, "split code");
            `CHK("split out", es, qsplit[p])
            for (int pr = 0; pr < 8; pr++) begin
               @(posedge clk);
               map_port <= 2'(p);
               map_prio <= 3'(pr);
               tick(1);
               eq = (es == 2'h0) ? 2'h0 : (es == 2'h1) ? {1'b0, map_prio[2]} : map_prio[2:1];
               `CHK("queue map", eq, map_queue)
            end
         end
         wr_reg(adr(p, `PC_OFS_OPCTL), 8'h07);
         rd_chk(adr(p, `PC_OFS_OPCTL), 8'h06, "split kept");
         wr_reg(adr(p, `PC_OFS_OPCTL), 8'h00);
      end
      wr_reg(16'h1030, 8'hFF);
      rd_chk(16'h1030, 8'h00, "unmapped");
      rd_chk(16'h401F, 8'h00, "no port four");
      rd_chk(16'h1021, 8'h00, "next offset");
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(adr(1, `PC_OFS_OPCTL), 8'hC0);
      ce <= 1'b1;
      rd_chk(adr(1, `PC_OFS_OPCTL), 8'h00, "ce low write");
      // mid-run reset brings every field back
      wr_reg(adr(0, `PC_OFS_MASK), 8'h07);
      wr_reg(adr(1, `PC_OFS_OPCTL), 8'hC6);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      chk_reset();
      wrap_up();
   end

endmodule : port_irq_op_regs_test
